// [dscmd_core.sv]
// Command interpreter: NVM address, logic output, reverse initialization
`timescale 1ns/1ps
`default_nettype none

module dscmd_core
(
    input  wire logic               clk_sys_i,
    input  wire logic               reset_n_i,
    input  wire logic               cmd_valid_i,
    input  wire dscmd_pkg::dscmd_cmd_s cmd_i,
    input  wire logic               slot_start_i,
    input  wire logic               nvm_programmed_i,
    input  wire logic [3:0]         nvm_value_i,
    input  wire logic               undervoltage_flag_i,
    input  wire logic [3:0]         pin_levels_i,
    input  wire logic               bus_fault_i,
    output logic                    nvm_write_o,
    output logic [3:0]              nvm_wdata_o,
    output logic                    logic_out_level_o,
    output logic                    bus_switch_close_o,
    output logic                    fault_test_o,
    output logic [3:0]              dev_addr_o,
    output logic [1:0]              group_number_o,
    output logic                    initialized_o,
    output dscmd_pkg::dscmd_rsp_s   rsp_o
);

    logic [3:0]  dev_addr_ff;
    logic [1:0]  group_ff;
    logic        init_ff;
    logic        nvm_we_ff;
    logic        bs_req_ff;
    logic        bus_fault_ff;
    logic        switch_ff;
    logic        logic_out_ff;
    logic        load_done_ff;
    logic        nvm_write_ff;
    logic [3:0]  nvm_wdata_ff;
    logic [15:0] fault_cnt_ff;
    logic        test_ff;
    logic        test_fault_ff;
    dscmd_pkg::dscmd_rsp_e pend_kind_ff;
    logic        pend_long_ff;
    dscmd_pkg::dscmd_rsp_s rsp_ff;

    logic        good;
    logic        addr_hit;
    logic        is_clear;
    logic        is_nvm;
    logic        is_lclr;
    logic        is_lset;
    logic        is_rev;
    logic        nvm_commit;
    logic [3:0]  prog_addr;
    logic        keep_bits;
    logic        start_test;
    logic        test_done;
    logic [7:0]  rsp_high;
    logic [7:0]  nvm_low;
    logic [7:0]  status_low;
    logic [7:0]  rev_high;
    logic [7:0]  rev_low;
    dscmd_pkg::dscmd_rsp_s nxt_rsp;

    // Discard on CRC error and silently drop unknown codes
    assign good     = cmd_valid_i && cmd_i.crc_ok;
    assign addr_hit = (cmd_i.addr == dev_addr_ff);
    assign prog_addr = cmd_i.data[3:0];
    assign is_clear = good && (cmd_i.cmd == dscmd_pkg::CMD_CLEAR)
                      && (addr_hit
                      || cmd_i.addr == dscmd_pkg::ADDR_GLOBAL);
    assign is_nvm   = good && cmd_i.long_word
                      && (cmd_i.cmd == dscmd_pkg::CMD_NVM)
                      && (cmd_i.data[7:4] == dscmd_pkg::NVM_MARK)
                      && (cmd_i.addr == prog_addr) && addr_hit;
    assign is_lclr  = good && addr_hit
                      && (cmd_i.cmd == dscmd_pkg::CMD_LOGIC_CLR);
    assign is_lset  = good && addr_hit
                      && (cmd_i.cmd == dscmd_pkg::CMD_LOGIC_SET);
    // Only an open, uninitialized device takes reverse initialization
    assign is_rev   = good && cmd_i.long_word
                      && (cmd_i.cmd == dscmd_pkg::CMD_REV_INIT)
                      && !init_ff && !switch_ff;
    // Programming needs a blank store and the earlier write enable
    assign nvm_commit = is_nvm && !nvm_programmed_i && nvm_we_ff;

    // A global reverse init with a nonzero program address keeps the
    // write enable and switch bits, so a blank part can be prepared and
    // close its switch; the fault test must follow the same rule
    assign keep_bits  = (cmd_i.addr != dscmd_pkg::ADDR_GLOBAL)
                        || (prog_addr != dscmd_pkg::ADDR_GLOBAL);
    assign start_test = is_rev && keep_bits && cmd_i.data[6];
    assign test_done  = test_ff && (fault_cnt_ff == 16'h0000);

    // Answer fields; the high byte is shared by the NVM and logic answers
    assign rsp_high   = {dev_addr_ff, dscmd_pkg::RSP_PAD4};
    assign nvm_low    = {dscmd_pkg::NVM_MARK,
                         nvm_programmed_i ? nvm_value_i
                                          : nvm_wdata_ff};
    assign status_low = {nvm_we_ff, undervoltage_flag_i,
                         logic_out_ff, switch_ff, pin_levels_i};
    assign rev_high   = {dev_addr_ff, dscmd_pkg::RSP_PAD3, bus_fault_ff};
    assign rev_low    = {nvm_we_ff, bs_req_ff, dscmd_pkg::GROUP_ZERO,
                         dev_addr_ff};

    // Address after power-up comes from the store once it is written.
    // Loading waits one clock after release so no port feeds the reset.
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            load_done_ff <= 1'b0;
            dev_addr_ff  <= dscmd_pkg::RST_ADDR;
            group_ff     <= dscmd_pkg::RST_GROUP;
            init_ff      <= dscmd_pkg::RST_BIT;
            nvm_we_ff    <= dscmd_pkg::RST_BIT;
            bs_req_ff    <= dscmd_pkg::RST_BIT;
        end
        else if (!load_done_ff)
        begin
            load_done_ff <= 1'b1;
            if (nvm_programmed_i)
                dev_addr_ff <= nvm_value_i;
        end
        else if (is_clear)
        begin
            // Clear also drops the loaded address; a programmed part
            // gets it back from the store at the next power-up
            dev_addr_ff <= dscmd_pkg::RST_ADDR;
            group_ff    <= dscmd_pkg::RST_GROUP;
            init_ff     <= dscmd_pkg::RST_BIT;
            nvm_we_ff   <= dscmd_pkg::RST_BIT;
            bs_req_ff   <= dscmd_pkg::RST_BIT;
        end
        else if (is_rev)
        begin
            dev_addr_ff <= prog_addr;
            group_ff    <= dscmd_pkg::GROUP_ZERO;
            init_ff     <= 1'b1;
            // Global address with program address zero: write enable and switch bits not kept
            if (cmd_i.addr == dscmd_pkg::ADDR_GLOBAL && prog_addr != 4'h0)
            begin
                nvm_we_ff <= cmd_i.data[7];
                bs_req_ff <= cmd_i.data[6];
            end
            else if (cmd_i.addr != dscmd_pkg::ADDR_GLOBAL)
            begin
                nvm_we_ff <= cmd_i.data[7];
                bs_req_ff <= cmd_i.data[6];
            end
            else
            begin
                nvm_we_ff <= 1'b0;
                bs_req_ff <= 1'b0;
            end
        end
        else if (nvm_commit)
            nvm_we_ff <= 1'b0;
    end

    // One-time store write strobe; an already written store is left alone
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            nvm_write_ff <= 1'b0;
            nvm_wdata_ff <= 4'h0;
        end
        else
        begin
            nvm_write_ff <= nvm_commit;
            if (nvm_commit)
                nvm_wdata_ff <= prog_addr;
        end
    end

    // Logic output pin
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            logic_out_ff <= dscmd_pkg::RST_BIT;
        else if (is_clear)
            logic_out_ff <= 1'b0;
        else if (is_lclr)
            logic_out_ff <= 1'b0;
        else if (is_lset)
            logic_out_ff <= 1'b1;
    end

    // Fault test runs once per accepted init with the switch bit set;
    // a Clear aborts it and leaves the switch open
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            test_ff       <= 1'b0;
            test_fault_ff <= 1'b0;
            fault_cnt_ff  <= 16'h0000;
        end
        else if (is_clear)
            test_ff <= 1'b0;
        else if (start_test)
        begin
            test_ff       <= 1'b1;
            test_fault_ff <= 1'b0;
            fault_cnt_ff  <= 16'(dscmd_pkg::FAULT_TEST_CYC - 1);
        end
        else if (test_ff)
        begin
            if (bus_fault_i)
                test_fault_ff <= 1'b1;
            if (test_done)
                test_ff <= 1'b0;
            else
                fault_cnt_ff <= fault_cnt_ff - 16'h0001;
        end
    end

    // Switch closes only when the whole test saw no fault
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            switch_ff    <= 1'b0;
            bus_fault_ff <= 1'b0;
        end
        else if (is_clear)
        begin
            switch_ff    <= 1'b0;
            bus_fault_ff <= 1'b0;
        end
        else if (test_done)
        begin
            bus_fault_ff <= test_fault_ff || bus_fault_i;
            switch_ff    <= !(test_fault_ff || bus_fault_i);
        end
    end

    // Remember what to answer; address zero never answers
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pend_kind_ff <= dscmd_pkg::DSCMD_RSP_NONE;
            pend_long_ff <= 1'b0;
        end
        else if (cmd_valid_i)
        begin
            pend_long_ff <= cmd_i.long_word;
            if (!good || cmd_i.addr == dscmd_pkg::ADDR_GLOBAL)
                pend_kind_ff <= dscmd_pkg::DSCMD_RSP_NONE;
            else if (is_nvm)
                pend_kind_ff <= dscmd_pkg::DSCMD_RSP_NVM;
            else if (is_lclr || is_lset)
                pend_kind_ff <= dscmd_pkg::DSCMD_RSP_LOGIC;
            else if (is_rev)
                pend_kind_ff <= dscmd_pkg::DSCMD_RSP_REVINIT;
            else
                pend_kind_ff <= dscmd_pkg::DSCMD_RSP_NONE;
        end
        else if (slot_start_i)
            // Answer once: a later slot without a new word stays silent
            pend_kind_ff <= dscmd_pkg::DSCMD_RSP_NONE;
    end

    // Next answer; sampled only at a slot start, so it may follow the
    // live state freely in between
    always_comb
    begin
        nxt_rsp           = '0;
        nxt_rsp.long_word = pend_long_ff;
        case (pend_kind_ff)
            dscmd_pkg::DSCMD_RSP_NVM:
            begin
                nxt_rsp.valid = 1'b1;
                nxt_rsp.data  = {rsp_high, nvm_low};
            end
            dscmd_pkg::DSCMD_RSP_LOGIC:
            begin
                nxt_rsp.valid = 1'b1;
                nxt_rsp.data  = {rsp_high, status_low};
            end
            dscmd_pkg::DSCMD_RSP_REVINIT:
            begin
                // The short-word form of this answer is never valid
                nxt_rsp.valid = pend_long_ff;
                nxt_rsp.data  = {rev_high, rev_low};
            end
            default:
            begin
                nxt_rsp.valid = 1'b0;
                nxt_rsp.data  = 16'h0000;
            end
        endcase
    end

    // Response is taken at the start of the next slot, never the current
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rsp_ff <= '0;
        else if (slot_start_i)
            rsp_ff <= nxt_rsp;
    end

    assign nvm_write_o        = nvm_write_ff;
    assign nvm_wdata_o        = nvm_wdata_ff;
    assign logic_out_level_o  = logic_out_ff;
    assign bus_switch_close_o = switch_ff;
    assign fault_test_o       = test_ff;
    assign dev_addr_o         = dev_addr_ff;
    assign group_number_o     = group_ff;
    assign initialized_o      = init_ff;
    assign rsp_o              = rsp_ff;

endmodule

`default_nettype wire

// [dscmd_core_properties.sv]
// Port checker of the command interpreter, bound to the core
`timescale 1ns/1ps
`default_nettype none
module dscmd_core_properties
(
    input wire logic                   clk_sys_i,
    input wire logic                   reset_n_i,
    input wire logic                   cmd_valid_i,
    input wire dscmd_pkg::dscmd_cmd_s  cmd_i,
    input wire logic                   slot_start_i,
    input wire logic                   nvm_programmed_i,
    input wire logic [3:0]             nvm_value_i,
    input wire logic                   undervoltage_flag_i,
    input wire logic [3:0]             pin_levels_i,
    input wire logic                   bus_fault_i,
    input wire logic                   nvm_write_o,
    input wire logic [3:0]             nvm_wdata_o,
    input wire logic                   logic_out_level_o,
    input wire logic                   bus_switch_close_o,
    input wire logic                   fault_test_o,
    input wire logic [3:0]             dev_addr_o,
    input wire logic [1:0]             group_number_o,
    input wire logic                   initialized_o,
    input wire dscmd_pkg::dscmd_rsp_s  rsp_o
);
    localparam int FT_CYC = dscmd_pkg::FAULT_TEST_CYC;
    logic silent_ff;
    int   ft_cnt_ff;
    logic hit;
    assign hit = cmd_valid_i && cmd_i.crc_ok;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    // Last word was one that must never be answered
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
        if (!reset_n_i)
            silent_ff <= 1'b0;
        else if (cmd_valid_i)
            silent_ff <= cmd_i.addr == dscmd_pkg::ADDR_GLOBAL || !cmd_i.crc_ok
                || !(cmd_i.cmd inside {4'h9, 4'hC, 4'hD, 4'hF, 4'h7});
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
        if (!reset_n_i)
            ft_cnt_ff <= 0;
        else
            ft_cnt_ff <= fault_test_o ? ft_cnt_ff + 1 : 0;
    property p_nvm_write;
        nvm_write_o |-> $past(hit) && $past(cmd_i.long_word)
            && $past(cmd_i.cmd) == dscmd_pkg::CMD_NVM && !$past(nvm_programmed_i)
            && $past(cmd_i.addr) == nvm_wdata_o && $past(dev_addr_o) == nvm_wdata_o;
    endproperty
    a_nvm_write: assert property (p_nvm_write) else $error("bad store write");
    property p_lo_set;
        hit && cmd_i.cmd == dscmd_pkg::CMD_LOGIC_SET && cmd_i.addr == dev_addr_o
            |=> logic_out_level_o;
    endproperty
    a_lo_set: assert property (p_lo_set) else $error("output not set");
    property p_lo_clr;
        hit && cmd_i.cmd == dscmd_pkg::CMD_LOGIC_CLR && cmd_i.addr == dev_addr_o
            |=> !logic_out_level_o;
    endproperty
    a_lo_clr: assert property (p_lo_clr) else $error("output not cleared");
    property p_clear;
        hit && cmd_i.cmd == dscmd_pkg::CMD_CLEAR && (cmd_i.addr == 4'h0
            || cmd_i.addr == dev_addr_o) |=> !logic_out_level_o && !initialized_o
            && !bus_switch_close_o && dev_addr_o == dscmd_pkg::RST_ADDR;
    endproperty
    a_clear: assert property (p_clear) else $error("clear incomplete");
    property p_rsp_slot;
        !$stable(rsp_o) |-> $past(slot_start_i);
    endproperty
    a_rsp_slot: assert property (p_rsp_slot) else $error("response off slot");
    property p_silent;
        slot_start_i && silent_ff |=> !rsp_o.valid;
    endproperty
    a_silent: assert property (p_silent) else $error("answer not allowed");
    property p_fault_len;
        $fell(fault_test_o)
            && !$past(hit && cmd_i.cmd == dscmd_pkg::CMD_CLEAR)
            |-> ft_cnt_ff == FT_CYC;
    endproperty
    a_fault_len: assert property (p_fault_len) else $error("fault test length");
    property p_switch_close;
        $rose(bus_switch_close_o) |-> $past(fault_test_o) && !$past(bus_fault_i);
    endproperty
    a_switch_close: assert property (p_switch_close) else $error("switch closed");
    property p_revinit_refuse;
        cmd_valid_i && cmd_i.cmd == dscmd_pkg::CMD_REV_INIT && initialized_o
            |=> $stable(dev_addr_o) && $stable(group_number_o);
    endproperty
    a_revinit_refuse: assert property (p_revinit_refuse) else $error("re-init");
    c_nvm_write: cover property (nvm_write_o);
    c_fault_end: cover property ($fell(fault_test_o));
    c_rsp: cover property (rsp_o.valid);
endmodule
bind dscmd_core dscmd_core_properties u_dscmd_core_properties (.*);
`default_nettype wire

// [dscmd_master_model.sv]
// Bus master model handing framed words and slot marks to the slave
`timescale 1ns/1ps
`default_nettype none
module dscmd_master_model
(
    input  wire logic             clk_sys_i,
    output logic                  cmd_valid_o,
    output dscmd_pkg::dscmd_cmd_s cmd_o,
    output logic                  slot_start_o
);
    initial
    begin
        cmd_valid_o = 1'b0;
        cmd_o = '0;
        slot_start_o = 1'b0;
    end
    // CRC outcome travels as crc_ok; a bad word only when the bench asks
    task automatic send(input dscmd_pkg::dscmd_cmd_s c);
        @(posedge clk_sys_i);
        cmd_valid_o <= 1'b1;
        cmd_o <= c;
        @(posedge clk_sys_i);
        cmd_valid_o <= 1'b0;
        cmd_o <= ~c; // Released word must not keep its last value
    endtask
    task automatic slot();
        @(posedge clk_sys_i);
        slot_start_o <= 1'b1;
        @(posedge clk_sys_i);
        slot_start_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [dscmd_pkg.sv]
// Constants and carrier types for the bus slave command interpreter
package dscmd_pkg;

    localparam logic [3:0] CMD_NVM       = 4'h9;
    localparam logic [3:0] CMD_LOGIC_CLR = 4'hC;
    localparam logic [3:0] CMD_LOGIC_SET = 4'hD;
    localparam logic [3:0] CMD_REV_INIT  = 4'hF;
    localparam logic [3:0] CMD_CLEAR     = 4'h7;
    localparam logic [3:0] NVM_MARK      = 4'hF;
    localparam logic [3:0] ADDR_GLOBAL   = 4'h0;
    localparam logic [3:0] RSP_PAD4      = 4'h0;
    localparam logic [2:0] RSP_PAD3      = 3'h0;
    localparam logic [1:0] GROUP_ZERO    = 2'h0;

    // Value after reset of every control register
    localparam logic [3:0] RST_ADDR      = 4'h0;
    localparam logic [1:0] RST_GROUP     = 2'h0;
    localparam logic       RST_BIT       = 1'b0;

    // Bus fault test time: 200 us at 10 MHz
    localparam int         CLK_HZ        = 10000000;
    localparam int         FAULT_TEST_US = 200;
    localparam int         FAULT_TEST_CYC = FAULT_TEST_US * (CLK_HZ / 1000000);

    typedef enum logic [2:0] {
        DSCMD_RSP_NONE,
        DSCMD_RSP_NVM,
        DSCMD_RSP_LOGIC,
        DSCMD_RSP_REVINIT
    } dscmd_rsp_e;

    // Received word, already framed; crc_ok from the link front end
    typedef struct packed {
        logic [7:0] data;
        logic [3:0] addr;
        logic [3:0] cmd;
        logic       long_word;
        logic       crc_ok;
    } dscmd_cmd_s;

    // Response payload; the framer appends the slave CRC
    typedef struct packed {
        logic        valid;
        logic        long_word;
        logic [15:0] data;
    } dscmd_rsp_s;

endpackage

// [test_dsi_slave_cmd_nvm_logicout_revinit.sv]
// Self-checking bench of the command interpreter
`timescale 1ns/1ps
`default_nettype none
module test_dsi_slave_cmd_nvm_logicout_revinit;
    typedef struct packed {
        dscmd_pkg::dscmd_cmd_s c;
        logic                  rv;
        logic [15:0]           rd;
        logic                  lo;
    } dscmd_row_s;
    localparam dscmd_row_s ROWS [11] = '{
        {8'h85, 4'h0, 4'hF, 2'h3, 1'h0, 16'h0000, 1'h0},
        {8'h00, 4'h5, 4'hC, 2'h3, 1'h1, 16'h50CA, 1'h0},
        {8'h00, 4'h5, 4'hD, 2'h3, 1'h1, 16'h50EA, 1'h1},
        {8'h00, 4'h5, 4'hC, 2'h2, 1'h0, 16'h0000, 1'h1},
        {8'h00, 4'h5, 4'hE, 2'h3, 1'h0, 16'h0000, 1'h1},
        {8'h00, 4'h3, 4'hC, 2'h3, 1'h0, 16'h0000, 1'h1},
        {8'hF5, 4'h5, 4'h9, 2'h1, 1'h0, 16'h0000, 1'h1},
        {8'hF3, 4'h5, 4'h9, 2'h3, 1'h0, 16'h0000, 1'h1},
        {8'hF5, 4'h5, 4'h9, 2'h3, 1'h1, 16'h50F5, 1'h1},
        {8'hF5, 4'h5, 4'h9, 2'h3, 1'h1, 16'h50F5, 1'h1},
        {8'hC5, 4'h5, 4'hF, 2'h3, 1'h0, 16'h0000, 1'h1}};
    logic clk_sys_i, reset_n_i, slot_start_i, cmd_valid_i, nvm_write_o;
    logic nvm_programmed_i, undervoltage_flag_i, bus_fault_i, initialized_o;
    logic logic_out_level_o, bus_switch_close_o, fault_test_o;
    logic [3:0] nvm_value_i, pin_levels_i, nvm_wdata_o, dev_addr_o;
    logic [1:0] group_number_o;
    dscmd_pkg::dscmd_cmd_s cmd_i;
    dscmd_pkg::dscmd_rsp_s rsp_o;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    dscmd_core u_dscmd_core (.*);
    dscmd_master_model u_dscmd_master_model (.clk_sys_i(clk_sys_i),
        .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i), .slot_start_o(slot_start_i));
    initial
    begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    // One-time store: survives resets, written once by the core
    initial nvm_programmed_i = 1'b0;
    initial nvm_value_i = 4'h0;
    always @(posedge clk_sys_i)
        if (nvm_write_o === 1'b1 && !nvm_programmed_i)
        begin
            nvm_programmed_i <= 1'b1;
            nvm_value_i <= nvm_wdata_o;
        end
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic answer();
        u_dscmd_master_model.slot();
        @(posedge clk_sys_i);
        #1;
    endtask
    // Fault test runs thousands of cycles; bounded so a hang is caught
    task automatic wait_fault();
        int n;
        n = 0;
        @(posedge clk_sys_i);
        while (fault_test_o === 1'b1 && n < 2100)
        begin
            @(posedge clk_sys_i);
            n++;
        end
        #1;
    endtask
    task automatic power_up();
        @(posedge clk_sys_i);
        reset_n_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask
    initial
    begin
        reset_n_i = 1'b0;
        undervoltage_flag_i = 1'b1;
        pin_levels_i = 4'hA;
        bus_fault_i = 1'b0;
        power_up();
        check({15'h0000, logic_out_level_o}, 16'h0000, "reset level");
        foreach (ROWS[i])
        begin
            u_dscmd_master_model.send(ROWS[i].c);
            answer();
            check({15'h0000, rsp_o.valid}, {15'h0000, ROWS[i].rv}, "valid");
            if (ROWS[i].rv)
                check(rsp_o.data, ROWS[i].rd, "data");
            check({15'h0000, logic_out_level_o}, {15'h0000, ROWS[i].lo}, "lo");
            $display("row %0d done", i);
        end
        check({13'h0000, initialized_o, group_number_o}, 16'h0004, "init");
        check({12'h000, nvm_wdata_o}, 16'h0005, "store data");
        u_dscmd_master_model.send({8'h00, 4'h0, dscmd_pkg::CMD_CLEAR, 2'h3});
        answer();
        check({15'h0000, rsp_o.valid}, 16'h0000, "global quiet");
        check({11'h000, logic_out_level_o, dev_addr_o}, 16'h0000, "clr");
        $display("global clear done");
        power_up();
        check({12'h000, dev_addr_o}, 16'h0005, "reload");
        @(posedge clk_sys_i);
        bus_fault_i <= 1'b1;
        u_dscmd_master_model.send({8'h45, 4'h5, dscmd_pkg::CMD_REV_INIT, 2'h3});
        wait_fault();
        check({15'h0000, bus_switch_close_o}, 16'h0000, "fault open");
        answer();
        check(rsp_o.data, 16'h5145, "fault rsp");
        check({15'h0000, rsp_o.long_word}, 16'h0001, "long rsp");
        u_dscmd_master_model.send({8'h00, 4'h5, dscmd_pkg::CMD_CLEAR, 2'h3});
        bus_fault_i <= 1'b0;
        u_dscmd_master_model.send({8'h45, 4'h5, dscmd_pkg::CMD_REV_INIT, 2'h3});
        wait_fault();
        check({15'h0000, bus_switch_close_o}, 16'h0001, "closed");
        answer();
        check(rsp_o.data, 16'h5045, "closed rsp");
        $display("fault tests done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
